// >>> wake_led_regs.vh
// Purpose: constants for the wake/LED setup and bus environment registers
// Assumes: byte-wide register port, offsets are byte addresses
// Notes: included by the config design file, the assertion checks and the bench
// How it works
// - led mode resets to 00; eeprom load strobe sets it
// - driver flag cleared on command/config write
// - bit 4 picks level polarity; pattern select stays 0, so no pulse mode
// - wake select bits reset to zero
// - pulse lasts 150 ms; cardbus ignores selects
// - bit 3 reports memory space mapping
// - bit 2 reports io space mapping
// - bit 1 enables vital product data
// - power enable writable only in mode 11
// - capability-list bit follows power enable
// - capability pointer zero unless power enabled
// - aux power bit captured after reset
// - config writes need eeprom mode 11
`ifndef WAKE_LED_REGS_VH
`define WAKE_LED_REGS_VH
// ==========================================
// register offsets
`define EEPROM_CMD_OFFSET 8'h50
`define WAKE_LED_SETUP_OFFSET 8'h52
`define BUS_ENV_STATUS_OFFSET 8'h53
// ==========================================
// field positions
`define LED_MODE_HI 7
`define LED_MODE_LO 6
`define DRIVER_LOADED_BIT 5
`define WAKE_ACTIVITY_BIT 4
`define MEM_MAPPED_BIT 3
`define IO_MAPPED_BIT 2
`define VPD_ENABLE_BIT 1
`define POWER_ENABLE_BIT 0
`define AUX_POWER_BIT 4
`define BUS_WIDTH_BIT 3
`define EEPROM_MODE_HI_BIT 7
`define EEPROM_MODE_LO_BIT 6
// ==========================================
// values
`define CONFIG_WRITE_MODE 2'h3
`define CAP_ID_POWER 8'h01
`define CAP_PTR_POWER 8'hDC
`define NEXT_PTR_VPD 8'hE4
`define STATUS_CAP_LIST_BIT 4
// ==========================================
// timing
`define CLK_PERIOD_NS 25
`define WAKE_PULSE_MS 150
`define WAKE_PULSE_CYCLES ((`WAKE_PULSE_MS * 1000000) / `CLK_PERIOD_NS)
`endif

// >>> wake_pulse_timer.v
// Purpose: one-shot timer that holds a pulse for a set number of cycles
// Assumes: start is a one-cycle pulse
// Notes: restart while busy reloads the count
`timescale 1ns/1ps
module wake_pulse_timer #(
    parameter CYCLES = 6000000,
    parameter WIDTH = 23
) (
    input wire clk_in, // clock
    input wire nrst_in, // sync reset, active low
    input wire start_in, // begin pulse
    output reg busy_out // high while pulse lasts
);
    reg [WIDTH-1:0] count_reg;
    // ==========================================
    // countdown
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            count_reg <= {WIDTH{1'b0}};
            busy_out <= 1'b0;
        end else if (start_in) begin
            count_reg <= CYCLES[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1};
            busy_out <= 1'b1;
        end else if (count_reg != {WIDTH{1'b0}}) begin
            count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
        end else begin
            busy_out <= 1'b0;
        end
    end
endmodule // wake_pulse_timer

// >>> wake_led_config.v
// Purpose: wake/LED setup register and read-only bus environment status
// Assumes: byte register port and config snoop strobes synchronous to clk_in
// Notes: eeprom values are presented during load_in pulse
// Notes: pulse modes need a pattern bit that lives outside this byte
// Notes: read data holds until the next read strobe
`timescale 1ns/1ps
`include "wake_led_regs.vh"
module nic_config_wake_pci_status #(
    parameter PULSE_CYCLES = `WAKE_PULSE_CYCLES, // shorten in simulation
    parameter PULSE_WIDTH = 23 // timer width
) (
    input wire clk_in, // bus clock
    input wire nrst_in, // bus reset, active low
    input wire [7:0] addr_in, // register byte address
    input wire [7:0] wdata_in, // write data
    input wire wr_in, // register write strobe
    input wire rd_in, // register read strobe
    output reg [7:0] rdata_out, // read data
    input wire [1:0] eeprom_mode_in, // eeprom_mode_hi/lo from command reg
    input wire cmd_write_in, // command register written
    input wire cfg_write_in, // config space written
    input wire eeprom_load_in, // eeprom load strobe
    input wire [1:0] eeprom_led_in, // led mode from eeprom
    input wire eeprom_pm_in, // power enable from eeprom
    input wire mem_mapped_in, // registers in memory space
    input wire io_mapped_in, // registers in io space
    input wire aux_power_in, // aux power present level
    input wire bus64_in, // 64-bit slot detect
    input wire [2:0] bus_clock_in, // bus clock code
    input wire cardbus_in, // cardbus application
    input wire wake_event_in, // wake request pulse
    output reg wake_output_pin_out, // wake pin drive
    output reg [1:0] led_mode_select_out, // led mode
    output reg vpd_enable_out, // vital product data enable
    output reg power_mgmt_enable_out, // power management enable
    output reg status_cap_list_out, // config status bit 4
    output reg [7:0] cap_pointer_out, // config 34h
    output reg [7:0] cap_id_out, // power cap id
    output reg [7:0] cap_next_out, // power cap next pointer
    output reg pm_regs_valid_out // power regs valid
);
    reg driver_loaded_flag_reg;
    reg wake_activity_select_reg;
    reg wake_pattern_select_reg;
    reg aux_power_reg;
    reg aux_caught_reg;
    reg wake_level_reg;
    wire cfg_wr_ok;
    wire setup_wr;
    wire pulse_busy;
    wire [7:0] setup_value;
    wire [7:0] bus_env_value;
    wire pattern_eff;
    wire activity_eff;
    reg [1:0] led_mode_next;
    reg driver_loaded_next;
    reg activity_next;
    reg vpd_next;
    reg power_next;
    reg [7:0] rdata_next;
    reg wake_pin_next;

    // ==========================================
    // write qualification
    assign cfg_wr_ok = (eeprom_mode_in == `CONFIG_WRITE_MODE);
    assign setup_wr = wr_in && cfg_wr_ok && (addr_in == `WAKE_LED_SETUP_OFFSET);
    // cardbus ignores both wake selects
    assign pattern_eff = cardbus_in ? 1'b0 : wake_pattern_select_reg;
    assign activity_eff = cardbus_in ? 1'b0 : wake_activity_select_reg;

    // ==========================================
    // setup register next values
    // eeprom load outranks a software write in the same cycle
    always @* begin
        led_mode_next = led_mode_select_out;
        driver_loaded_next = driver_loaded_flag_reg;
        activity_next = wake_activity_select_reg;
        vpd_next = vpd_enable_out;
        power_next = power_mgmt_enable_out;
        if (eeprom_load_in) begin
            led_mode_next = eeprom_led_in;
            power_next = eeprom_pm_in;
            driver_loaded_next = 1'b0;
        end else begin
            if (setup_wr) begin
                led_mode_next = wdata_in[`LED_MODE_HI:`LED_MODE_LO];
                activity_next = wdata_in[`WAKE_ACTIVITY_BIT];
                vpd_next = wdata_in[`VPD_ENABLE_BIT];
                power_next = wdata_in[`POWER_ENABLE_BIT];
            end
            // a write of the flag itself wins over an auto-clear in same cycle
            if (setup_wr) begin
                driver_loaded_next = wdata_in[`DRIVER_LOADED_BIT];
            end else if (cmd_write_in || cfg_write_in) begin
                driver_loaded_next = 1'b0;
            end
        end
    end

    // setup register flops; wake selects clear so the pin idles active-high
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            led_mode_select_out <= 2'h0;
            driver_loaded_flag_reg <= 1'b0;
            wake_activity_select_reg <= 1'b0;
            vpd_enable_out <= 1'b0;
            power_mgmt_enable_out <= 1'b0;
        end else begin
            led_mode_select_out <= led_mode_next;
            driver_loaded_flag_reg <= driver_loaded_next;
            wake_activity_select_reg <= activity_next;
            vpd_enable_out <= vpd_next;
            power_mgmt_enable_out <= power_next;
        end
    end

    // pattern select has no bit in this byte; it stays at its reset default
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            wake_pattern_select_reg <= 1'b0;
        end else begin
            wake_pattern_select_reg <= wake_pattern_select_reg;
        end
    end

    // ==========================================
    // aux power captured once after reset
    // later changes on the pin are ignored until the next reset
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            aux_power_reg <= 1'b0;
            aux_caught_reg <= 1'b0;
        end else if (!aux_caught_reg) begin
            aux_power_reg <= aux_power_in;
            aux_caught_reg <= 1'b1;
        end
    end

    // ==========================================
    // register read values
    assign setup_value = {led_mode_select_out, driver_loaded_flag_reg, wake_activity_select_reg,
                          mem_mapped_in, io_mapped_in, vpd_enable_out, power_mgmt_enable_out};
    assign bus_env_value = {3'h0, aux_power_reg, bus64_in, bus_clock_in};

    // read decode, unmapped addresses read zero
    always @* begin
        rdata_next = rdata_out;
        if (rd_in) begin
            if (addr_in == `WAKE_LED_SETUP_OFFSET) begin
                rdata_next = setup_value;
            end else if (addr_in == `BUS_ENV_STATUS_OFFSET) begin
                rdata_next = bus_env_value;
            end else begin
                rdata_next = 8'h00;
            end
        end
    end

    // read data flop
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= rdata_next;
        end
    end

    // ==========================================
    // config space capability view
    // lags the enable by one cycle so config reads see a settled block
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            status_cap_list_out <= 1'b0;
            cap_pointer_out <= 8'h00;
            cap_id_out <= 8'h00;
            cap_next_out <= 8'h00;
            pm_regs_valid_out <= 1'b0;
        end else begin
            status_cap_list_out <= power_mgmt_enable_out;
            cap_pointer_out <= power_mgmt_enable_out ? `CAP_PTR_POWER : 8'h00;
            cap_id_out <= power_mgmt_enable_out ? `CAP_ID_POWER : 8'h00;
            cap_next_out <= (power_mgmt_enable_out && vpd_enable_out) ? `NEXT_PTR_VPD : 8'h00;
            pm_regs_valid_out <= power_mgmt_enable_out;
        end
    end

    // ==========================================
    // wake pin
    wake_pulse_timer #(
        .CYCLES(PULSE_CYCLES),
        .WIDTH(PULSE_WIDTH)
    ) u_pulse (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .start_in(wake_event_in && pattern_eff),
        .busy_out(pulse_busy)
    );

    // level mode latches the event until driver write clears it
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            wake_level_reg <= 1'b0;
        end else if (wake_event_in) begin
            wake_level_reg <= 1'b1;
        end else if (cfg_write_in) begin
            wake_level_reg <= 1'b0;
        end
    end

    // pin level before the output flop
    always @* begin
        if (pattern_eff) begin
            wake_pin_next = pulse_busy ^ activity_eff;
        end else begin
            wake_pin_next = wake_level_reg ^ activity_eff;
        end
    end

    // wake pin flop, low in reset matches the active-high idle level
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            wake_output_pin_out <= 1'b0;
        end else begin
            wake_output_pin_out <= wake_pin_next;
        end
    end
endmodule // nic_config_wake_pci_status

// >>> eeprom_image.sv
// Purpose: serial eeprom contents seen by the setup register at load time
// Assumes: image bits [2:1] led mode, [0] power enable
// Notes: outside a load the lines show the inverse, never a stale copy
`timescale 1ns/1ps
module eeprom_image (
    input wire logic load_in, // load strobe
    input wire logic [2:0] image_in, // stored image
    output logic [1:0] led_out, // led mode bits
    output logic pm_out // power enable bit
);
    // present image only while loading
    assign led_out = load_in ? image_in[2:1] : ~image_in[2:1];
    assign pm_out = load_in ? image_in[0] : ~image_in[0];
endmodule // eeprom_image

// >>> cfg_asserts.sv
// Purpose: port checks for the wake/led setup bank
// Assumes: one clock, sync active-low reset
// Notes: bound from tb_top
`timescale 1ns/1ps
`include "wake_led_regs.vh"
module cfg_asserts #(
    parameter PULSE_CYCLES = 20 // pulse length, unused by these checks
) (
    input wire logic clk_in, // clock
    input wire logic nrst_in, // sync reset, active low
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    input wire logic eeprom_load_in, // eeprom load strobe
    input wire logic mem_mapped_in, // memory mapping level
    input wire logic io_mapped_in, // io mapping level
    input wire logic bus64_in, // slot width level
    input wire logic power_mgmt_enable_out, // power enable
    input wire logic vpd_enable_out, // vpd enable
    input wire logic status_cap_list_out, // status capability bit
    input wire logic [7:0] addr_in, // byte address
    input wire logic [7:0] wdata_in, // write data
    input wire logic [7:0] rdata_out, // read data
    input wire logic [7:0] cap_pointer_out, // capability pointer
    input wire logic [7:0] cap_id_out, // capability id
    input wire logic [1:0] eeprom_mode_in, // eeprom mode bits
    input wire logic [1:0] eeprom_led_in, // eeprom led bits
    input wire logic [1:0] led_mode_select_out, // led mode
    input wire logic [2:0] bus_clock_in // bus clock code
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // ==========================================
    // write sequences
    sequence cfg_wr;
        wr_in && !eeprom_load_in && addr_in == `WAKE_LED_SETUP_OFFSET && eeprom_mode_in == `CONFIG_WRITE_MODE;
    endsequence
    sequence bad_wr;
        wr_in && !eeprom_load_in && eeprom_mode_in != `CONFIG_WRITE_MODE;
    endsequence
    led_write_a: assert property (cfg_wr |=> led_mode_select_out == $past(wdata_in[7:6]))
        else $error("led write lost");
    pm_vpd_write_a: assert property (cfg_wr |=> {vpd_enable_out, power_mgmt_enable_out} == $past(wdata_in[1:0]))
        else $error("enable write lost");
    write_lock_a: assert property (bad_wr |=> $stable(power_mgmt_enable_out) && $stable(led_mode_select_out))
        else $error("locked write took effect");
    led_load_a: assert property (eeprom_load_in && !wr_in |=> led_mode_select_out == $past(eeprom_led_in))
        else $error("led not loaded");
    cap_on_a: assert property (power_mgmt_enable_out |=> status_cap_list_out
        && cap_pointer_out == `CAP_PTR_POWER && cap_id_out == `CAP_ID_POWER) else $error("cap block missing");
    cap_off_a: assert property (!power_mgmt_enable_out |=> !status_cap_list_out
        && cap_pointer_out == 8'h00 && cap_id_out == 8'h00) else $error("cap block shown");
    bus_read_a: assert property (rd_in && addr_in == `BUS_ENV_STATUS_OFFSET |=>
        rdata_out[7:5] == 3'h0 && rdata_out[3:0] == $past({bus64_in, bus_clock_in})) else $error("bus status wrong");
    map_read_a: assert property (rd_in && addr_in == `WAKE_LED_SETUP_OFFSET |=>
        rdata_out[3:2] == $past({mem_mapped_in, io_mapped_in})) else $error("map bits wrong");
endmodule // cfg_asserts

// >>> tb_top.sv
// Purpose: self-checking bench for the wake/led setup bank
// Assumes: inputs change at falling edge
// Notes: integer model mirrors the register fields
`timescale 1ns/1ps
`include "wake_led_regs.vh"
module tb_top;
    logic clk_in = 0, nrst_in = 0, wr_in = 0, rd_in = 0, cmd_write_in = 0, cfg_write_in = 0, eeprom_load_in = 0;
    logic mem_mapped_in = 1, io_mapped_in = 0, aux_power_in = 1, bus64_in = 0, cardbus_in = 0, wake_event_in = 0;
    logic [7:0] addr_in = 0, wdata_in = 0, img = 0, rdata_out, cap_pointer_out, cap_id_out, cap_next_out;
    logic [1:0] eeprom_mode_in = 0, eeprom_led_in, led_mode_select_out;
    logic [2:0] bus_clock_in = 0;
    logic eeprom_pm_in, wake_output_pin_out, vpd_enable_out, power_mgmt_enable_out;
    logic status_cap_list_out, pm_regs_valid_out;
    logic [31:0] rs = 32'hCF7B;
    integer mismatches = 0, comparisons = 0, led = 0, drv = 0, act = 0, vpd = 0, pm = 0, i;
    nic_config_wake_pci_status #(.PULSE_CYCLES(20)) u_dut (.clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
        .rdata_out, .eeprom_mode_in, .cmd_write_in, .cfg_write_in, .eeprom_load_in, .eeprom_led_in, .eeprom_pm_in,
        .mem_mapped_in, .io_mapped_in, .aux_power_in, .bus64_in, .bus_clock_in, .cardbus_in, .wake_event_in,
        .wake_output_pin_out, .led_mode_select_out, .vpd_enable_out, .power_mgmt_enable_out, .status_cap_list_out,
        .cap_pointer_out, .cap_id_out, .cap_next_out, .pm_regs_valid_out);
    eeprom_image u_ee (.load_in(eeprom_load_in), .image_in(img[2:0]), .led_out(eeprom_led_in), .pm_out(eeprom_pm_in));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    function automatic logic [7:0] e52();
        return {led[1:0], drv[0], act[0], mem_mapped_in, io_mapped_in, vpd[0], pm[0]};
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    // register write, model follows only accepted writes
    task automatic wr(input logic [1:0] m, input logic [7:0] a, input logic [7:0] d);
        eeprom_mode_in = m;
        addr_in = a;
        wdata_in = d;
        wr_in = 1;
        @(negedge clk_in) wr_in = 0;
        if (m == 2'h3 && a == 8'h52) {led, drv, act, vpd, pm} = {30'h0, d[7:6], 31'h0, d[5], 31'h0, d[4],
            31'h0, d[1], 31'h0, d[0]};
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        addr_in = a;
        rd_in = 1;
        @(negedge clk_in) rd_in = 0;
        chk("rdata", e, rdata_out);
    endtask
    task automatic pulse_cfg();
        cfg_write_in = 1;
        @(negedge clk_in) cfg_write_in = 0;
        drv = 0;
        repeat (3) @(negedge clk_in);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end
    // hang guard
    initial begin
        #100000 mismatches++;
        close_out();
    end
    initial begin
        repeat (20) @(negedge clk_in);
        nrst_in = 1;
        @(negedge clk_in) aux_power_in = 0;
        rd(8'h52, e52());
        for (i = 0; i < 2; i++) begin
            bus_clock_in = i[2:0];
            bus64_in = ~bus64_in;
            rd(8'h53, {4'h1, bus64_in, bus_clock_in});
        end
        rd(8'h60, 8'h00);
        rs = xs(rs);
        img = rs[7:0];
        eeprom_load_in = 1;
        @(negedge clk_in) eeprom_load_in = 0;
        {led, pm} = {30'h0, img[2:1], 31'h0, img[0]};
        rd(8'h52, e52());
        wr(2'h3, 8'h51, 8'hFF);
        rd(8'h52, e52());
        for (i = 0; i < 24; i++) begin
            rs = xs(rs);
            {mem_mapped_in, io_mapped_in} = rs[10:9];
            wr(rs[12:11], 8'h52, rs[7:0]);
            @(negedge clk_in);
            chk("cap_ptr", pm ? `CAP_PTR_POWER : 8'h00, cap_pointer_out);
            chk("cap_id", pm ? `CAP_ID_POWER : 8'h00, cap_id_out);
            chk("cap_list", pm[0], status_cap_list_out);
            chk("cap_next", (pm[0] && vpd[0]) ? `NEXT_PTR_VPD : 8'h00, cap_next_out);
            chk("pm_valid", pm[0], pm_regs_valid_out);
            chk("led_out", led[1:0], led_mode_select_out);
            rd(8'h52, e52());
        end
        wr(2'h3, 8'h52, 8'h20);
        pulse_cfg();
        rd(8'h52, e52());
        wr(2'h3, 8'h52, 8'h20);
        rd(8'h52, e52());
        cmd_write_in = 1;
        @(negedge clk_in) cmd_write_in = 0;
        drv = 0;
        rd(8'h52, e52());
        for (i = 0; i < 2; i++) begin
            wr(2'h3, 8'h52, {3'h0, i[0], 4'h0});
            pulse_cfg();
            chk("wake_idle", i[0], wake_output_pin_out);
            wake_event_in = 1;
            @(negedge clk_in) wake_event_in = 0;
            repeat (3) @(negedge clk_in);
            chk("wake_active", {7'h0, ~i[0]}, wake_output_pin_out);
        end
        cardbus_in = 1;
        pulse_cfg();
        chk("wake_cardbus", 8'h00, wake_output_pin_out);
        // second reset in mid-run: aux power is captured afresh, then held
        aux_power_in = 0;
        nrst_in = 0;
        repeat (2) @(negedge clk_in);
        nrst_in = 1;
        @(negedge clk_in) aux_power_in = 1;
        {led, drv, act, vpd, pm} = 160'h0;
        rd(8'h53, {4'h0, bus64_in, bus_clock_in});
        rd(8'h52, e52());
        chk("wake_reset", 8'h00, wake_output_pin_out);
        close_out();
    end
endmodule // tb_top
bind nic_config_wake_pci_status cfg_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (.clk_in, .nrst_in, .wr_in, .rd_in,
    .eeprom_load_in, .mem_mapped_in, .io_mapped_in, .bus64_in, .power_mgmt_enable_out, .vpd_enable_out,
    .status_cap_list_out, .addr_in, .wdata_in, .rdata_out, .cap_pointer_out, .cap_id_out, .eeprom_mode_in,
    .eeprom_led_in, .led_mode_select_out, .bus_clock_in);
